// File: core/adc_ctl_pkg.sv
// package: register layout, codes and types for the converter control block
package adc_ctl_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADC_CONTROL_ONE_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] SAMPLE_TIME_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] RESULT_OFS = 4'h8;
	localparam int ON_BIT = 15;
	localparam int IDLE_STOP_BIT = 13;
	localparam int FORMAT_LSB = 8;
	localparam int TRIG_LSB = 5;
	localparam int STOP_AUTO_BIT = 4;
	localparam int AUTO_START_BIT = 2;
	localparam int SAMPLE_BIT = 1;
	localparam int DONE_BIT = 0;
	localparam int RESULT_W = 10;
	localparam logic [7:0] SAMPLE_TIME_RESET = 8'h01;

	typedef enum logic [2:0] {
		FMT_INT16 = 3'b000,
		FMT_SINT16 = 3'b001,
		FMT_FRAC16 = 3'b010,
		FMT_SFRAC16 = 3'b011,
		FMT_INT32 = 3'b100,
		FMT_SINT32 = 3'b101,
		FMT_FRAC32 = 3'b110,
		FMT_SFRAC32 = 3'b111
	} result_format_t;

	typedef enum logic [2:0] {
		TRIG_MANUAL = 3'b000,
		TRIG_EXT_PIN = 3'b001,
		TRIG_TIMER = 3'b010,
		TRIG_CHARGE = 3'b011,
		TRIG_AUTO = 3'b111
	} trigger_source_select_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic sample;
		logic convert_start;
	} core_ctl_t;
endpackage

// File: core/adc_sample_convert_control.sv
// converter control: mode, sampling, trigger, result format and status
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ns
module adc_sample_convert_control
	import adc_ctl_pkg::*;
#(
	parameter int RES_W = RESULT_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire adc_ctl_pkg::reg_req_t req,
	output logic [31:0] rdata,
	input wire logic device_idle,
	input wire logic ext_irq_pin_zero,
	input wire logic ext_irq_rising,
	input wire logic timer_period_match,
	input wire logic charge_time_unit_event,
	input wire logic adc_irq,
	input wire logic core_conv_done,
	input wire logic [RES_W-1:0] core_result,
	output adc_ctl_pkg::core_ctl_t core_ctl,
	output logic [31:0] result_word
);
	import adc_ctl_pkg::*;

	// the format table is laid out for a ten-bit result only
	if (RES_W != RESULT_W) begin : g_bad_width
		$error("result width must be ten bits");
	end

	// bits of the control word that exist; all others read zero
	localparam logic [31:0] CTL_USED = (32'h1 << ON_BIT) | (32'h1 << IDLE_STOP_BIT)
		| (32'h7 << FORMAT_LSB) | (32'h7 << TRIG_LSB) | (32'h1 << STOP_AUTO_BIT)
		| (32'h1 << AUTO_START_BIT) | (32'h1 << SAMPLE_BIT) | (32'h1 << DONE_BIT);

	// ***********************************************************
	// control register
	// ***********************************************************
	logic module_on;
	logic idle_stop;
	result_format_t result_format;
	trigger_source_select_t trigger_source_select;
	logic stop_autostart_on_irq;
	logic auto_sample_start;
	logic sample_active;
	logic done;
	logic [7:0] sample_time;
	logic converting;
	logic [7:0] sample_count;
	logic [2:0] pin_sync;
	logic pin_prev;
	logic running;
	logic wr_ctl;
	logic trig_event;
	logic conv_start;
	logic done_event;

	assign wr_ctl = req.wr && req.addr == ADC_CONTROL_ONE_OFS;
	assign running = module_on && !(idle_stop && device_idle);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			module_on <= 1'b0;
			idle_stop <= 1'b0;
			result_format <= FMT_INT16;
			trigger_source_select <= TRIG_MANUAL;
			stop_autostart_on_irq <= 1'b0;
		end else if (wr_ctl) begin
			module_on <= req.wdata[ON_BIT];
			idle_stop <= req.wdata[IDLE_STOP_BIT];
			result_format <= result_format_t'(req.wdata[FORMAT_LSB +: 3]);
			trigger_source_select <= trigger_source_select_t'(req.wdata[TRIG_LSB +: 3]);
			stop_autostart_on_irq <= req.wdata[STOP_AUTO_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			auto_sample_start <= 1'b0;
		end else if (running && stop_autostart_on_irq && adc_irq) begin
			auto_sample_start <= 1'b0;
		end else if (wr_ctl) begin
			auto_sample_start <= req.wdata[AUTO_START_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sample_time <= SAMPLE_TIME_RESET;
		end else if (req.wr && req.addr == SAMPLE_TIME_OFS) begin
			sample_time <= req.wdata[7:0];
		end
	end

	// ***********************************************************
	// trigger selection
	// ***********************************************************
	// pin is asynchronous: three stages, edge only when stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_sync <= 3'h0;
			pin_prev <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], ext_irq_pin_zero};
			if (pin_sync[1] == pin_sync[2]) begin
				pin_prev <= pin_sync[2];
			end
		end
	end

	logic pin_edge;
	assign pin_edge = (pin_sync[1] == pin_sync[2]) && (pin_sync[2] != pin_prev)
		&& (pin_sync[2] == ext_irq_rising);

	always_comb begin
		trig_event = 1'b0;
		unique case (trigger_source_select)
			TRIG_MANUAL: trig_event = wr_ctl && !req.wdata[SAMPLE_BIT];
			TRIG_EXT_PIN: trig_event = pin_edge;
			TRIG_TIMER: trig_event = timer_period_match;
			TRIG_CHARGE: trig_event = charge_time_unit_event;
			TRIG_AUTO: trig_event = sample_count >= sample_time;
			default: trig_event = 1'b0; // reserved codes never trigger
		endcase
	end

	assign conv_start = running && sample_active && !converting && trig_event;
	assign done_event = running && converting && core_conv_done;

	// ***********************************************************
	// sample and convert sequencing
	// ***********************************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !running) begin
			sample_count <= 8'h00;
		end else if (sample_active && !converting && sample_count != 8'hFF) begin
			sample_count <= sample_count + 8'h01;
		end else if (!sample_active) begin
			sample_count <= 8'h00;
		end
	end

	// sample bit: hardware clear on trigger, hardware set on autostart
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !running) begin
			sample_active <= 1'b0;
		end else if (conv_start) begin
			sample_active <= 1'b0;
		end else if (auto_sample_start && !converting && !sample_active) begin
			sample_active <= 1'b1;
		end else if (wr_ctl && req.wdata[SAMPLE_BIT] && !converting) begin
			sample_active <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n || !running) begin
			converting <= 1'b0;
		end else if (conv_start) begin
			converting <= 1'b1;
		end else if (done_event) begin
			converting <= 1'b0;
		end
	end

	// set wins over software clear; a one write is ignored
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			done <= 1'b0;
		end else if (done_event) begin
			done <= 1'b1;
		end else if (conv_start) begin
			done <= 1'b0;
		end else if (wr_ctl && !req.wdata[DONE_BIT]) begin
			done <= 1'b0;
		end
	end

	assign core_ctl.sample = sample_active;
	assign core_ctl.convert_start = conv_start;

	// ***********************************************************
	// result formatting
	// ***********************************************************
	function automatic logic [31:0] format_result(input result_format_t f, input logic [RES_W-1:0] d);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (f)
			FMT_INT16: w = {22'h0, d};
			FMT_SINT16: w = {16'h0, {6{d[RES_W-1]}}, d};
			FMT_FRAC16: w = {16'h0, d, 6'h00};
			FMT_SFRAC16: w = {16'h0, d, 6'h00};
			FMT_INT32: w = {22'h0, d};
			FMT_SINT32: w = {{22{d[RES_W-1]}}, d};
			FMT_FRAC32: w = {d, 22'h0};
			FMT_SFRAC32: w = {d, 22'h0};
		endcase
		return w;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			result_word <= 32'h0000_0000;
		end else if (done_event) begin
			result_word <= format_result(result_format, core_result);
		end
	end

	// ***********************************************************
	// register read
	// ***********************************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata <= 32'h0000_0000;
		end else if (req.rd) begin
			rdata <= 32'h0000_0000;
			if (req.addr == ADC_CONTROL_ONE_OFS) begin
				rdata[ON_BIT] <= module_on;
				rdata[IDLE_STOP_BIT] <= idle_stop;
				rdata[FORMAT_LSB +: 3] <= result_format;
				rdata[TRIG_LSB +: 3] <= trigger_source_select;
				rdata[STOP_AUTO_BIT] <= stop_autostart_on_irq;
				rdata[AUTO_START_BIT] <= auto_sample_start;
				rdata[SAMPLE_BIT] <= sample_active;
				rdata[DONE_BIT] <= done;
			end else if (req.addr == SAMPLE_TIME_OFS) begin
				rdata[7:0] <= sample_time;
			end else if (req.addr == RESULT_OFS) begin
				rdata <= result_word;
			end
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// ***********************************************************
	// checks
	// ***********************************************************
	a_off_no_sample: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!running |=> !sample_active && !converting) else $error("sampling while disabled");
	a_idle_stops: assert property (@(posedge sys_clk) disable iff (!rst_n)
		module_on && idle_stop && device_idle |-> !conv_start) else $error("conversion in idle");
	a_manual_trigger: assert property (@(posedge sys_clk) disable iff (!rst_n)
		running && sample_active && !converting && trigger_source_select == TRIG_MANUAL
		&& wr_ctl && !req.wdata[SAMPLE_BIT] |=> converting && !sample_active)
		else $error("manual trigger missed");
	a_timer_trigger: assert property (@(posedge sys_clk) disable iff (!rst_n)
		running && sample_active && !converting && trigger_source_select == TRIG_TIMER
		&& timer_period_match |=> converting) else $error("timer trigger missed");
	a_reserved_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		trigger_source_select inside {3'b100, 3'b101, 3'b110} |-> !conv_start)
		else $error("reserved trigger fired");
	a_done_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_event |=> done) else $error("done not set");
	a_done_start_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
		conv_start |=> !done) else $error("done not cleared at start");
	a_done_one_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!done && !done_event ##1 !done_event |-> !done) else $error("done set without cause");
	a_autostart_sample: assert property (@(posedge sys_clk) disable iff (!rst_n)
		running && auto_sample_start && done_event |=> ##1 sample_active || !running || !auto_sample_start)
		else $error("autostart did not resample");
	a_stop_autostart: assert property (@(posedge sys_clk) disable iff (!rst_n)
		running && stop_autostart_on_irq && adc_irq |=> !auto_sample_start)
		else $error("autostart not stopped");
	a_frac32_format: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_event && result_format == FMT_FRAC32 |=> result_word == {$past(core_result), 22'h0})
		else $error("format 110 wrong");
	a_sint32_format: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_event && result_format == FMT_SINT32 |=> result_word[31] == result_word[9])
		else $error("format 101 wrong");

	// ***********************************************************
	// format checks
	// ***********************************************************
	a_int16_format: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_event && result_format == FMT_INT16
		|=> result_word == {22'h0, $past(core_result)})
		else $error("format 000 wrong");
	a_frac16_format: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_event && result_format == FMT_FRAC16
		|=> result_word == {16'h0, $past(core_result), 6'h00})
		else $error("format 010 wrong");
	a_sfrac16_format: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_event && result_format == FMT_SFRAC16
		|=> result_word[31:16] == 16'h0 && result_word[15] == $past(core_result[RES_W-1]) && result_word[5:0] == 6'h00)
		else $error("format 011 wrong");
	a_int32_format: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_event && result_format == FMT_INT32
		|=> result_word == {22'h0, $past(core_result)})
		else $error("format 100 wrong");
	a_sfrac32_format: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_event && result_format == FMT_SFRAC32
		|=> result_word[31] == $past(core_result[RES_W-1]) && result_word[21:0] == 22'h0)
		else $error("format 111 wrong");
	a_sint16_format: assert property (@(posedge sys_clk) disable iff (!rst_n)
		done_event && result_format == FMT_SINT16
		|=> result_word[31:16] == 16'h0 && result_word[15:10] == {6{$past(core_result[RES_W-1])}})
		else $error("format 001 wrong");
	a_result_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!done_event
		|=> $stable(result_word))
		else $error("result changed without conversion");

	// ***********************************************************
	// sequencing checks
	// ***********************************************************
	a_pin_trigger: assert property (@(posedge sys_clk) disable iff (!rst_n)
		running && sample_active && !converting && trigger_source_select == TRIG_EXT_PIN && pin_edge
		|=> converting)
		else $error("pin trigger missed");
	a_charge_trigger: assert property (@(posedge sys_clk) disable iff (!rst_n)
		running && sample_active && !converting && trigger_source_select == TRIG_CHARGE && charge_time_unit_event
		|=> converting)
		else $error("charge trigger missed");
	a_counter_trigger: assert property (@(posedge sys_clk) disable iff (!rst_n)
		running && sample_active && !converting && trigger_source_select == TRIG_AUTO && sample_count >= sample_time
		|=> converting)
		else $error("counter trigger missed");
	a_sw_sample_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		running && wr_ctl && req.wdata[SAMPLE_BIT] && !converting && !conv_start
		|=> sample_active)
		else $error("software sample start lost");
	a_auto_sample_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		running && auto_sample_start && !converting && !sample_active
		|=> sample_active)
		else $error("autostart did not set sample");
	a_hw_sample_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
		conv_start
		|=> !sample_active)
		else $error("sample not cleared at start");
	a_sample_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!auto_sample_start && !sample_active && !(wr_ctl && req.wdata[SAMPLE_BIT])
		|=> !sample_active)
		else $error("sampling began without cause");
	a_idle_halts: assert property (@(posedge sys_clk) disable iff (!rst_n)
		module_on && idle_stop && device_idle
		|=> !sample_active && !converting)
		else $error("block active in idle");
	a_done_sw_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_ctl && !req.wdata[DONE_BIT] && !done_event
		|=> !done)
		else $error("done clear lost");
	a_clear_keeps_conv: assert property (@(posedge sys_clk) disable iff (!rst_n)
		running && converting && wr_ctl && !req.wdata[DONE_BIT] && !done_event
		|=> converting)
		else $error("done clear stopped conversion");

	// ***********************************************************
	// read path checks
	// ***********************************************************
	a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!req.rd
		|=> rdata == 32'h0000_0000)
		else $error("read data outside read cycle");
	a_ctl_unused_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		req.rd && req.addr == ADC_CONTROL_ONE_OFS
		|=> (rdata & ~CTL_USED) == 32'h0000_0000)
		else $error("unused control bits not zero");
endmodule // adc_sample_convert_control

// File: sim/analog_core_model.sv
// model of the sample-and-hold and successive approximation core
`timescale 1ns/1ns
module analog_core_model #(
	parameter int CONV_CYC = 20
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire adc_ctl_pkg::core_ctl_t core_ctl,
	input wire logic [adc_ctl_pkg::RESULT_W-1:0] sample_value,
	output logic core_conv_done,
	output logic [adc_ctl_pkg::RESULT_W-1:0] core_result
);
	import adc_ctl_pkg::*;
	int count;
	// ****************
	// conversion timer
	// ****************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			count <= 0;
			core_conv_done <= 1'b0;
			core_result <= '0;
		end else begin
			core_conv_done <= 1'b0;
			// result not held outside done, so a late read shows garbage
			core_result <= ~core_result;
			if (core_ctl.convert_start) begin
				count <= CONV_CYC;
			end else if (count == 1) begin
				count <= 0;
				core_conv_done <= 1'b1;
				core_result <= sample_value;
			end else if (count > 1) begin
				count <= count - 1;
			end
		end
	end
endmodule // analog_core_model

// File: sim/adc_sample_convert_control_bench.sv
// bench for the converter control block
`timescale 1ns/1ns
module adc_sample_convert_control_bench;
	import adc_ctl_pkg::*;
	typedef struct packed {
		logic [2:0] fmt;
		logic [9:0] raw;
		logic [31:0] exp;
	} fmt_row_t;
	localparam logic [31:0] ON = 32'h0000_8000;
	fmt_row_t rows [9] = '{'{3'h0, 10'h2A5, 32'h0000_02A5}, '{3'h1, 10'h2A5, 32'h0000_FEA5},
		'{3'h2, 10'h2A5, 32'h0000_A940}, '{3'h3, 10'h2A5, 32'h0000_A940}, '{3'h4, 10'h2A5, 32'h0000_02A5},
		'{3'h5, 10'h2A5, 32'hFFFF_FEA5}, '{3'h5, 10'h155, 32'h0000_0155}, '{3'h6, 10'h2A5, 32'hA940_0000},
		'{3'h7, 10'h2A5, 32'hA940_0000}};
	logic [2:0] trigs [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	reg_req_t req = '0;
	logic device_idle = 1'b0;
	logic ext_pin = 1'b0;
	logic ext_rising = 1'b1;
	logic timer_match = 1'b0;
	logic charge_event = 1'b0;
	logic adc_irq = 1'b0;
	logic [RESULT_W-1:0] raw_value = '0;
	logic [RESULT_W-1:0] core_result;
	logic core_conv_done;
	core_ctl_t core_ctl;
	logic [31:0] rdata;
	logic [31:0] result_word;
	logic [31:0] starts = '0;
	logic [31:0] v;
	logic [31:0] w;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;

	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (core_ctl.convert_start === 1'b1) starts <= starts + 1;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			complete_run();
		end
	end

	adc_sample_convert_control i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
		.device_idle(device_idle), .ext_irq_pin_zero(ext_pin), .ext_irq_rising(ext_rising),
		.timer_period_match(timer_match), .charge_time_unit_event(charge_event), .adc_irq(adc_irq),
		.core_conv_done(core_conv_done), .core_result(core_result), .core_ctl(core_ctl),
		.result_word(result_word));
	analog_core_model i_core (.sys_clk(sys_clk), .rst_n(rst_n), .core_ctl(core_ctl),
		.sample_value(raw_value), .core_conv_done(core_conv_done), .core_result(core_result));

	// ************
	// shared tasks
	// ************
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			fail_count++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		req <= '0;
	endtask
	task automatic rd_check(input logic [3:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		req <= '0;
		#1;
		check(rdata, exp);
	endtask
	task automatic wait_conv();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (core_conv_done !== 1'b1 && n < 100);
		@(posedge sys_clk);
		#1;
	endtask
	// pulse events are one cycle; the pin edge has to cross the synchroniser
	task automatic fire(input logic [2:0] t);
		int n;
		logic [31:0] s0;
		n = 0;
		s0 = starts;
		@(posedge sys_clk);
		if (t == 3'h1) ext_pin <= 1'b1;
		if (t == 3'h2) timer_match <= 1'b1;
		if (t == 3'h3) charge_event <= 1'b1;
		@(posedge sys_clk);
		timer_match <= 1'b0;
		charge_event <= 1'b0;
		while (starts === s0 && n < 200) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check(starts, s0 + 1);
	endtask

	// **********
	// main cases
	// **********
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd_check(ADC_CONTROL_ONE_OFS, 32'h0);
		rd_check(SAMPLE_TIME_OFS, 32'h1);
		rd_check(RESULT_OFS, 32'h0);
		wr(4'hC, 32'hFFFF_FFFF);
		rd_check(4'hC, 32'h0);
		wr(ADC_CONTROL_ONE_OFS, 32'hFFFF_5FF9);
		rd_check(ADC_CONTROL_ONE_OFS, 32'h0000_07F0);
		check({31'h0, core_ctl.sample}, 32'h0);
		@(posedge sys_clk);
		device_idle <= 1'b1;
		wr(ADC_CONTROL_ONE_OFS, 32'h0000_A002);
		wr(ADC_CONTROL_ONE_OFS, 32'h0000_A002);
		#1;
		check({31'h0, core_ctl.sample}, 32'h0);
		@(posedge sys_clk);
		device_idle <= 1'b0;
		wr(ADC_CONTROL_ONE_OFS, 32'h0000_A002);
		#1;
		check({31'h0, core_ctl.sample}, 32'h1);
		wr(ADC_CONTROL_ONE_OFS, 32'h0);
		wr(SAMPLE_TIME_OFS, 32'h40);
		wr(ADC_CONTROL_ONE_OFS, ON);
		for (int i = 0; i < 9; i++) begin
			@(posedge sys_clk);
			raw_value <= rows[i].raw;
			w = ON | (32'(rows[i].fmt) << 8);
			wr(ADC_CONTROL_ONE_OFS, w | 32'h2);
			v = starts;
			wr(ADC_CONTROL_ONE_OFS, w);
			#1;
			check(starts, v + 1);
			wait_conv();
			check(result_word, rows[i].exp);
			rd_check(ADC_CONTROL_ONE_OFS, w | 32'h1);
		end
		for (int i = 0; i < 4; i++) begin
			w = ON | (32'(trigs[i]) << 5);
			wr(ADC_CONTROL_ONE_OFS, w | 32'h3);
			rd_check(ADC_CONTROL_ONE_OFS, w | 32'h3);
			fire(trigs[i]);
			rd_check(ADC_CONTROL_ONE_OFS, w);
			wait_conv();
			rd_check(ADC_CONTROL_ONE_OFS, w | 32'h1);
			@(posedge sys_clk);
			ext_pin <= 1'b0;
		end
		wr(ADC_CONTROL_ONE_OFS, 32'h0000_80F4);
		rd_check(ADC_CONTROL_ONE_OFS, 32'h0000_80F6);
		fire(3'h7);
		wait_conv();
		rd_check(ADC_CONTROL_ONE_OFS, 32'h0000_80F7);
		@(posedge sys_clk);
		adc_irq <= 1'b1;
		@(posedge sys_clk);
		adc_irq <= 1'b0;
		rd_check(ADC_CONTROL_ONE_OFS, 32'h0000_80F3);
		fire(3'h7);
		wait_conv();
		rd_check(ADC_CONTROL_ONE_OFS, 32'h0000_80F1);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		rd_check(ADC_CONTROL_ONE_OFS, 32'h0);
		check(result_word, 32'h0);
		complete_run();
	end
endmodule // adc_sample_convert_control_bench
